// File: rtl/hdr_pkg.sv
// Function
// - Drive 32 data and 4 parity outputs with received values after resynchronising.
// - While connect request stays high, present the received I-field word.
// - After each burst's last word, present the received checkword.
// - Parity errors are only flagged; data and bad parity pass unchanged.
// - Raise receive parity error for each burst word, checkword or undecided I-field word with bad parity; status words are not flagged.
// - Before connection, check I-field parity every clock; hold error until cleared.
// - Raise checkword error with the checkword that follows a failing burst.
// - Count burst words, seed the computed checkword with that count, compare.
// - Raise resync error on loss of synchronisation by overrun or underrun.
// - Mode 000 resets all counters and state machines; use at power-up.
// - Mode 100 runs a walking-zero generator over host data, parity and all three error outputs.
// - In diagnostic mode the word type select cycles through all eight codes.
// - Mode 101 is normal functional receive operation.
// - The local clock is the domain that channel clock and data resync into.
// - State machines and resync logic run from the fast state machine clock.
// - Functional word type: 000 burst, 001 I-field, 010 checkword, 011 status.
package hdr_pkg;

  // ------------------------------------------------------------
  // Mode and word type codes
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] MODE_DIAG = 3'h4;
  localparam logic [2:0] MODE_FUNC = 3'h5;
  localparam logic [2:0] SEL_BURST = 3'h0;
  localparam logic [2:0] SEL_IFIELD = 3'h1;
  localparam logic [2:0] SEL_CHECK = 3'h2;
  localparam logic [2:0] SEL_STATUS = 3'h3;
  localparam logic [2:0] SEL_IDLE_FIRST = 3'h5;
  localparam logic [2:0] SEL_IDLE_LAST = 3'h7;

  // ------------------------------------------------------------
  // Register map and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ERRCNT = 8'h08;
  localparam int CTRL_ACCEPT_BIT = 0;
  localparam int CTRL_REJECT_BIT = 1;
  localparam int CTRL_COUNT_EN_BIT = 2;
  localparam logic CTRL_COUNT_EN_RESET = 1'b1;
  localparam int ERR_PARITY_LSB = 0;
  localparam int ERR_CHECK_LSB = 8;
  localparam int ERR_SYNC_LSB = 16;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int UNDERRUN_NS = 48;
  localparam int CLOCK_NS = 4;
  localparam logic [3:0] UNDERRUN_CYCLES = 4'((UNDERRUN_NS + CLOCK_NS - 1) / CLOCK_NS);
  localparam int FIFO_AW = 2;
  localparam int WALK_W = 39;
  localparam logic [WALK_W-1:0] WALK_RESET = {{(WALK_W-1){1'b1}}, 1'b0};

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] parity;
    logic burst;
    logic packet;
    logic request;
    logic check;
  } hdr_word_s;

  typedef enum logic [2:0] {ST_RESET, ST_DIAG, ST_IDLE, ST_REQ, ST_CONN, ST_BURST} hdr_state_e;

endpackage : hdr_pkg

// File: rtl/hdr_sync_bits.sv
`timescale 1ns/100ps
module hdr_sync_bits #(
  parameter int W = 1
) (
  input wire logic clock, // Destination clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic clockEn, // Freezes state while low
  input wire logic [W-1:0] asyncIn, // Level from another domain
  output logic [W-1:0] syncOut // Resynchronised level
);

  logic [W-1:0] stage1;

  // ------------------------------------------------------------
  // Two flip-flop synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      stage1 <= '0;
      syncOut <= '0;
    end
    else if (clockEn)
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule : hdr_sync_bits

// File: rtl/hdr_link_rx.sv
`timescale 1ns/100ps
module hdr_link_rx (
  input wire logic linkClk, // Channel clock
  input wire logic linkRstReq, // Reset request level from local side
  input wire hdr_pkg::hdr_word_s chIn, // Channel word and control lines
  input wire logic clock, // Local clock
  input wire logic sys_rst, // Local synchronous reset
  input wire logic clockEn, // Freezes local state while low
  input wire logic pop, // Take the head record
  output hdr_pkg::hdr_word_s headWord, // Head record
  output logic notEmpty, // Head record present
  output logic overrunToggle // Toggles on each overrun, link domain
);

  localparam int DEPTH = 1 << hdr_pkg::FIFO_AW;
  localparam int PW = hdr_pkg::FIFO_AW + 1;

  typedef struct packed {
    logic rstS1;
    logic rstS2;
    logic [PW-1:0] wBin;
    logic [PW-1:0] wGray;
    logic [PW-1:0] rS1;
    logic [PW-1:0] rS2;
    logic prevBurst;
    logic prevReq;
    logic prevPkt;
    logic ovr;
    hdr_pkg::hdr_word_s [DEPTH-1:0] mem;
  } wr_s;

  typedef struct packed {
    logic [PW-1:0] rBin;
    logic [PW-1:0] rGray;
    logic [PW-1:0] wS1;
    logic [PW-1:0] wS2;
  } rd_s;

  wr_s w, next_w;
  rd_s r, next_r;
  logic active;
  logic full;

  // ------------------------------------------------------------
  // Link side: capture and write
  // ------------------------------------------------------------
  always_comb
  begin
    next_w = w;
    next_w.rstS1 = linkRstReq;
    next_w.rstS2 = w.rstS1;
    next_w.rS1 = r.rGray;
    next_w.rS2 = w.rS1;
    next_w.prevBurst = chIn.burst;
    next_w.prevReq = chIn.request;
    next_w.prevPkt = chIn.packet;
    full = (w.wGray == {~w.rS2[PW-1:PW-2], w.rS2[PW-3:0]});
    active = chIn.request | chIn.burst | chIn.packet | w.prevBurst | w.prevReq | w.prevPkt;
    if (active)
    begin
      if (full)
      begin
        next_w.ovr = ~w.ovr;
      end
      else
      begin
        next_w.mem[w.wBin[PW-2:0]] = chIn;
        next_w.mem[w.wBin[PW-2:0]].check = w.prevBurst & ~chIn.burst;
        next_w.wBin = w.wBin + 1'b1;
        next_w.wGray = next_w.wBin ^ (next_w.wBin >> 1);
      end
    end
  end

  always_ff @(posedge linkClk)
  begin
    if (w.rstS2)
    begin
      w <= '0;
      w.rstS1 <= linkRstReq;
      w.rstS2 <= w.rstS1;
    end
    else
    begin
      w <= next_w;
    end
  end

  // ------------------------------------------------------------
  // Local side: read through gray pointers
  // ------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.wS1 = w.wGray;
    next_r.wS2 = r.wS1;
    if (pop && notEmpty)
    begin
      next_r.rBin = r.rBin + 1'b1;
      next_r.rGray = next_r.rBin ^ (next_r.rBin >> 1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      r <= '0;
    end
    else if (clockEn)
    begin
      r <= next_r;
    end
  end

  assign notEmpty = (r.rGray != r.wS2);
  assign headWord = w.mem[r.rBin[PW-2:0]];
  assign overrunToggle = w.ovr;

endmodule : hdr_link_rx

// File: rtl/hdr_dest_rx.sv
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps
module hdr_dest_rx (
  input wire logic clock, // Local and state machine clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic clockEn, // Freezes all local state while low
  input wire logic [2:0] opModeSel, // Mode pins, bit 2 most significant
  input wire logic linkClk, // Channel clock
  input wire hdr_pkg::hdr_word_s chIn, // Channel data, parity, burst, packet, request
  input wire logic [7:0] regAddr, // Register byte address
  input wire logic [31:0] regWrData, // Register write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [31:0] regRdData, // Read data, cycle after the strobe
  output logic [31:0] rxDataOut, // Host data
  output logic [3:0] rxParityOut, // Host byte parity
  output logic [2:0] wordTypeSel, // Type of word on host data
  output logic dataValid, // Host word valid
  output logic rxParityErr, // Parity error
  output logic rxCheckwordErr, // Checkword error
  output logic resyncErr, // Loss of synchronisation
  output logic burstOut, // Channel burst line
  output logic packetOut // Channel packet line
);

  typedef struct packed {
    hdr_pkg::hdr_state_e st;
    logic [2:0] sel;
    logic [31:0] data;
    logic [3:0] par;
    logic valid;
    logic perr;
    logic lerr;
    logic serr;
    logic burstO;
    logic packetO;
    logic decided;
    logic [31:0] accXor;
    logic [31:0] wordCnt;
    logic [3:0] emptyCnt;
    logic [hdr_pkg::WALK_W-1:0] walk;
    logic ovrSeen;
    logic countEn;
    logic [7:0] perrCnt;
    logic [7:0] lerrCnt;
    logic [7:0] serrCnt;
    logic [31:0] rdData;
    logic linkRst;
  } hdr_state_s;

  hdr_state_s s, next_s;
  logic [2:0] modeSync;
  logic ovrSync;
  logic pop;
  logic notEmpty;
  hdr_pkg::hdr_word_s head;
  logic linkOvr;
  logic modeRst;
  logic accept;
  logic reject;
  logic headBad;
  logic heldBad;
  logic underrun;
  logic overrun;

  // ------------------------------------------------------------
  // Crossings
  // ------------------------------------------------------------
  hdr_sync_bits #(
    .W(4)
  ) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .clockEn(clockEn),
    .asyncIn({opModeSel, linkOvr}),
    .syncOut({modeSync, ovrSync})
  );

  hdr_link_rx u_link (
    .linkClk(linkClk),
    .linkRstReq(s.linkRst),
    .chIn(chIn),
    .clock(clock),
    .sys_rst(sys_rst),
    .clockEn(clockEn),
    .pop(pop),
    .headWord(head),
    .notEmpty(notEmpty),
    .overrunToggle(linkOvr)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic parityBad(input logic [31:0] d, input logic [3:0] p);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      bad = bad | ~(^{d[8*i +: 8], p[i]});
    end
    return bad;
  endfunction : parityBad

  function automatic logic [7:0] bump(input logic [7:0] c, input logic ev, input logic clr, input logic en);
    logic [7:0] n;
    n = clr ? 8'h00 : c;
    if (ev && en && n != 8'hff)
    begin
      n = n + 8'h01;
    end
    return n;
  endfunction : bump

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    modeRst = (modeSync != hdr_pkg::MODE_DIAG) && (modeSync != hdr_pkg::MODE_FUNC);
    accept = regWr && regAddr == hdr_pkg::REG_CTRL && regWrData[hdr_pkg::CTRL_ACCEPT_BIT];
    reject = regWr && regAddr == hdr_pkg::REG_CTRL && regWrData[hdr_pkg::CTRL_REJECT_BIT];
    pop = (modeSync == hdr_pkg::MODE_FUNC) && notEmpty;
    headBad = parityBad(head.data, head.parity);
    heldBad = parityBad(s.data, s.par);
    overrun = (ovrSync != s.ovrSeen);
    underrun = (s.st == hdr_pkg::ST_BURST) && !notEmpty && (s.emptyCnt == hdr_pkg::UNDERRUN_CYCLES - 4'h1);
    next_s.ovrSeen = ovrSync;
    next_s.linkRst = modeRst;
    next_s.valid = 1'b0;
    if (modeRst)
    begin
      next_s.st = hdr_pkg::ST_RESET;
      next_s.sel = hdr_pkg::SEL_IDLE_FIRST;
      next_s.data = '0;
      next_s.par = '0;
      next_s.perr = 1'b0;
      next_s.lerr = 1'b0;
      next_s.serr = 1'b0;
      next_s.burstO = 1'b0;
      next_s.packetO = 1'b0;
      next_s.decided = 1'b0;
      next_s.accXor = '0;
      next_s.wordCnt = '0;
      next_s.emptyCnt = '0;
      next_s.walk = hdr_pkg::WALK_RESET;
      next_s.perrCnt = '0;
      next_s.lerrCnt = '0;
      next_s.serrCnt = '0;
    end
    else if (modeSync == hdr_pkg::MODE_DIAG)
    begin
      next_s.st = hdr_pkg::ST_DIAG;
      next_s.walk = {s.walk[hdr_pkg::WALK_W-2:0], s.walk[hdr_pkg::WALK_W-1]};
      {next_s.data, next_s.par, next_s.perr, next_s.lerr, next_s.serr} = s.walk;
      next_s.sel = s.sel + 3'h1;
      next_s.valid = 1'b1;
    end
    else
    begin
      if (s.st == hdr_pkg::ST_DIAG || s.st == hdr_pkg::ST_RESET)
      begin
        next_s.st = hdr_pkg::ST_IDLE;
        next_s.perr = 1'b0;
        next_s.lerr = 1'b0;
        next_s.data = '0;
        next_s.par = '0;
      end
      if (pop)
      begin
        next_s.emptyCnt = '0;
        next_s.burstO = head.burst;
        next_s.packetO = head.packet;
        if (head.check)
        begin
          next_s.data = head.data;
          next_s.par = head.parity;
          next_s.sel = hdr_pkg::SEL_CHECK;
          next_s.valid = 1'b1;
          next_s.perr = headBad;
          next_s.lerr = (s.accXor ^ s.wordCnt) != head.data;
          next_s.accXor = '0;
          next_s.wordCnt = '0;
          next_s.st = hdr_pkg::ST_CONN;
        end
        else if (head.burst)
        begin
          next_s.data = head.data;
          next_s.par = head.parity;
          next_s.sel = hdr_pkg::SEL_BURST;
          next_s.valid = 1'b1;
          next_s.perr = headBad;
          next_s.lerr = 1'b0;
          next_s.accXor = s.accXor ^ head.data;
          next_s.wordCnt = s.wordCnt + 32'h1;
          next_s.st = hdr_pkg::ST_BURST;
        end
        else if (!head.request)
        begin
          next_s.st = hdr_pkg::ST_IDLE;
          next_s.decided = 1'b0;
          next_s.perr = 1'b0;
          next_s.lerr = 1'b0;
        end
        else if (s.st == hdr_pkg::ST_IDLE || s.st == hdr_pkg::ST_REQ)
        begin
          next_s.data = head.data;
          next_s.par = head.parity;
          next_s.sel = hdr_pkg::SEL_IFIELD;
          next_s.valid = 1'b1;
          next_s.perr = headBad && !s.decided;
          next_s.st = hdr_pkg::ST_REQ;
        end
        else
        begin
          next_s.sel = hdr_pkg::SEL_STATUS;
          next_s.lerr = 1'b0;
          next_s.perr = 1'b0;
          next_s.st = hdr_pkg::ST_CONN;
        end
      end
      else
      begin
        unique case (s.st)
          hdr_pkg::ST_IDLE:
          begin
            next_s.sel = (s.sel >= hdr_pkg::SEL_IDLE_FIRST && s.sel != hdr_pkg::SEL_IDLE_LAST) ?
              s.sel + 3'h1 : hdr_pkg::SEL_IDLE_FIRST;
            next_s.valid = 1'b1;
            next_s.perr = 1'b0;
            next_s.data = '0;
            next_s.par = '0;
          end
          hdr_pkg::ST_REQ:
          begin
            next_s.perr = heldBad && !s.decided;
          end
          hdr_pkg::ST_BURST:
          begin
            next_s.emptyCnt = underrun ? 4'h0 : s.emptyCnt + 4'h1;
          end
          hdr_pkg::ST_CONN:
          begin
            next_s.sel = hdr_pkg::SEL_STATUS;
          end
          hdr_pkg::ST_RESET, hdr_pkg::ST_DIAG:
          begin
          end
        endcase
      end
      if (s.st == hdr_pkg::ST_REQ && (accept || reject))
      begin
        next_s.decided = 1'b1;
        next_s.perr = 1'b0;
        if (accept)
        begin
          next_s.st = hdr_pkg::ST_CONN;
          next_s.sel = hdr_pkg::SEL_STATUS;
        end
      end
      if (overrun || underrun)
      begin
        next_s.serr = 1'b1;
      end
      next_s.perrCnt = bump(s.perrCnt, next_s.perr && next_s.valid, 1'b0, s.countEn);
      next_s.lerrCnt = bump(s.lerrCnt, next_s.lerr && next_s.valid, 1'b0, s.countEn);
      next_s.serrCnt = bump(s.serrCnt, overrun || underrun, 1'b0, s.countEn);
    end
    if (regWr && regAddr == hdr_pkg::REG_CTRL)
    begin
      next_s.countEn = regWrData[hdr_pkg::CTRL_COUNT_EN_BIT];
    end
    if (regWr && regAddr == hdr_pkg::REG_ERRCNT && !modeRst)
    begin
      next_s.perrCnt = bump(s.perrCnt, next_s.perr && next_s.valid, 1'b1, s.countEn);
      next_s.lerrCnt = bump(s.lerrCnt, next_s.lerr && next_s.valid, 1'b1, s.countEn);
      next_s.serrCnt = bump(s.serrCnt, overrun || underrun, 1'b1, s.countEn);
      next_s.serr = overrun || underrun;
    end
    next_s.rdData = '0;
    if (regRd)
    begin
      unique case (regAddr)
        hdr_pkg::REG_CTRL:
          next_s.rdData = {29'h0, s.countEn, 2'h0};
        hdr_pkg::REG_STATUS:
          next_s.rdData = {20'h0, s.decided, s.st, modeSync, s.sel, s.serr, notEmpty};
        hdr_pkg::REG_ERRCNT:
          next_s.rdData = {8'h00, s.serrCnt, s.lerrCnt, s.perrCnt};
        default:
          next_s.rdData = '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.st <= hdr_pkg::ST_RESET;
      s.sel <= hdr_pkg::SEL_IDLE_FIRST;
      s.walk <= hdr_pkg::WALK_RESET;
      s.countEn <= hdr_pkg::CTRL_COUNT_EN_RESET;
      s.linkRst <= 1'b1;
    end
    else if (clockEn)
    begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign regRdData = s.rdData;
  assign rxDataOut = s.data;
  assign rxParityOut = s.par;
  assign wordTypeSel = s.sel;
  assign dataValid = s.valid;
  assign rxParityErr = s.perr;
  assign rxCheckwordErr = s.lerr;
  assign resyncErr = s.serr;
  assign burstOut = s.burstO;
  assign packetOut = s.packetO;

endmodule : hdr_dest_rx

// File: bench/hdr_chan_src.sv
`timescale 1ns/100ps
module hdr_chan_src (
  output logic linkClk, // Channel clock, only within frames
  output hdr_pkg::hdr_word_s chIn // Channel lines
);
  logic run = 1'b0;
  logic [31:0] lastData = 32'h0;

  initial
  begin
    linkClk = 1'b0;
    chIn = '0;
    #1.7;
    forever
    begin
      #6;
      linkClk = (run || linkClk) ? ~linkClk : 1'b0;
    end
  end

  function automatic logic [3:0] odd_par(input logic [31:0] d);
    for (int i = 0; i < 4; i++)
      odd_par[i] = ~^d[8*i+:8];
  endfunction : odd_par

  // One record per link edge; flip spoils the parity of byte 0
  task automatic put(input logic [31:0] d, input logic flip, input logic bst, input logic req);
    @(posedge linkClk);
    chIn <= {d, odd_par(d) ^ {3'h0, flip}, bst, bst, req, 1'b0};
    lastData = d;
  endtask : put

  task automatic ifield(input logic [31:0] d, input logic flip, input int n);
    run = 1'b1;
    repeat (n) put(d, flip, 1'b0, 1'b1);
  endtask : ifield

  task automatic burst(input int n, input logic [31:0] base, input int flipAt, input logic bad);
    logic [31:0] cw;
    run = 1'b1;
    cw = 32'(n) ^ {31'h0, bad};
    for (int i = 0; i < n; i++)
    begin
      put(base + 32'(i), i == flipAt, 1'b1, 1'b1);
      cw = cw ^ (base + 32'(i));
    end
    put(cw, 1'b0, 1'b0, 1'b1);
  endtask : burst

  // Released lines toggle so no stale word looks like data
  task automatic finish;
    run = 1'b1;
    repeat (3) put(~lastData, 1'b0, 1'b0, 1'b0);
    @(posedge linkClk);
    run = 1'b0;
  endtask : finish
endmodule : hdr_chan_src

// File: bench/hdr_dest_rx_monitor.sv
`timescale 1ns/100ps
module hdr_dest_rx_monitor (
  input wire logic clock, // Clock
  input wire logic sys_rst, // Reset
  input wire logic clockEn, // Run enable
  input wire logic [2:0] opModeSel, // Mode pins
  input wire logic regRd, // Read strobe
  input wire logic regWr, // Write strobe
  input wire logic [31:0] regRdData, // Read data
  input wire logic [31:0] rxDataOut, // Host data
  input wire logic [3:0] rxParityOut, // Host parity
  input wire logic [2:0] wordTypeSel, // Word type
  input wire logic dataValid, // Word valid
  input wire logic rxParityErr, // Parity error
  input wire logic rxCheckwordErr, // Checkword error
  input wire logic resyncErr // Sync error
);
  logic [3:0] diagRun;
  logic [3:0] funcRun;
  logic [38:0] walk;
  logic parBad;

  assign walk = {rxDataOut, rxParityOut, rxParityErr, rxCheckwordErr, resyncErr};
  assign parBad = ~^{rxDataOut[7:0], rxParityOut[0]} | ~^{rxDataOut[15:8], rxParityOut[1]}
    | ~^{rxDataOut[23:16], rxParityOut[2]} | ~^{rxDataOut[31:24], rxParityOut[3]};

  // Cycles the mode pins stood still, so the sync delay is behind us
  always_ff @(posedge clock)
  begin
    diagRun <= (sys_rst || !clockEn || opModeSel != hdr_pkg::MODE_DIAG) ? 4'h0 : diagRun + {3'h0, diagRun != 4'hf};
    funcRun <= (sys_rst || !clockEn || opModeSel != hdr_pkg::MODE_FUNC) ? 4'h0 : funcRun + {3'h0, funcRun != 4'hf};
  end

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_RD_QUIET: assert property ($past(clockEn) && !$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside answer cycle");
  AST_RESYNC_HOLD: assert property (resyncErr && !regWr && funcRun >= 4'h4 |=> resyncErr)
    else $error("sync error dropped by itself");
  AST_DIAG_SEL: assert property (diagRun >= 4'h8 |-> wordTypeSel == $past(wordTypeSel) + 3'h1)
    else $error("diag select not counting");
  AST_DIAG_WALK: assert property (diagRun >= 4'h8 |-> $countones(walk) == 38 && walk == {$past(walk[37:0]), $past(walk[38])})
    else $error("walking zero broken");
  AST_IDLE_ROTATE: assert property (funcRun >= 4'h8 && $past(wordTypeSel) >= 3'h5 && wordTypeSel >= 3'h5
    |-> wordTypeSel == (($past(wordTypeSel) == 3'h7) ? 3'h5 : $past(wordTypeSel) + 3'h1))
    else $error("idle select order wrong");
  AST_BURST_PARITY: assert property (funcRun >= 4'h8 && dataValid && wordTypeSel == hdr_pkg::SEL_BURST
    |-> rxParityErr == parBad)
    else $error("parity flag disagrees with word");
  AST_CHECK_ERR: assert property (funcRun >= 4'h8 && $rose(rxCheckwordErr)
    |-> dataValid && wordTypeSel == hdr_pkg::SEL_CHECK)
    else $error("checkword error without checkword");
  AST_RESET_CLEAR: assert property (disable iff (1'b0) sys_rst && clockEn
    |=> rxDataOut == 32'h0 && wordTypeSel == hdr_pkg::SEL_IDLE_FIRST && !dataValid && !resyncErr)
    else $error("outputs not cleared by reset");

  COV_DIAG: cover property (diagRun == 4'hf);
  COV_RESYNC: cover property ($rose(resyncErr));
  COV_IFIELD_BAD: cover property (dataValid && wordTypeSel == hdr_pkg::SEL_IFIELD && rxParityErr);
endmodule : hdr_dest_rx_monitor

bind hdr_dest_rx hdr_dest_rx_monitor u_hdr_dest_rx_monitor (.clock(clock), .sys_rst(sys_rst), .clockEn(clockEn),
  .opModeSel(opModeSel), .regRd(regRd), .regWr(regWr), .regRdData(regRdData), .rxDataOut(rxDataOut),
  .rxParityOut(rxParityOut), .wordTypeSel(wordTypeSel), .dataValid(dataValid), .rxParityErr(rxParityErr),
  .rxCheckwordErr(rxCheckwordErr), .resyncErr(resyncErr));

// File: bench/tb.sv
`timescale 1ns/100ps
module tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clockEn = 1'b1;
  logic [2:0] opModeSel = hdr_pkg::MODE_RESET;
  logic linkClk;
  hdr_pkg::hdr_word_s chIn;
  logic [7:0] regAddr = 8'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic [31:0] rxDataOut;
  logic [3:0] rxParityOut;
  logic [2:0] wordTypeSel;
  logic dataValid;
  logic rxParityErr;
  logic rxCheckwordErr;
  logic resyncErr;
  logic burstOut;
  logic packetOut;
  int errCount = 0;
  int checked = 0;

  always #2 clock = ~clock;

  hdr_chan_src u_hdr_chan_src (.linkClk(linkClk), .chIn(chIn));
  hdr_dest_rx u_hdr_dest_rx (.clock(clock), .sys_rst(sys_rst), .clockEn(clockEn), .opModeSel(opModeSel),
    .linkClk(linkClk), .chIn(chIn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .rxDataOut(rxDataOut), .rxParityOut(rxParityOut), .wordTypeSel(wordTypeSel),
    .dataValid(dataValid), .rxParityErr(rxParityErr), .rxCheckwordErr(rxCheckwordErr), .resyncErr(resyncErr),
    .burstOut(burstOut), .packetOut(packetOut));

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic ok, input string what);
    checked++;
    if (ok !== 1'b1)
    begin
      errCount++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    chk(regRdData === exp, what);
  endtask : rd

  task automatic wait_word(input logic [2:0] s);
    int n;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (!(dataValid === 1'b1 && wordTypeSel === s) && n < 400);
    if (n >= 400)
    begin
      chk(1'b0, "word wait timed out");
      print_verdict();
    end
  endtask : wait_word

  task automatic t_ifield;
    fork
      u_hdr_chan_src.ifield(32'h1234_5678, 1'b1, 8);
      begin
        wait_word(hdr_pkg::SEL_IFIELD);
        chk(rxDataOut === 32'h1234_5678, "I-field data");
        chk(rxParityOut === (u_hdr_chan_src.odd_par(32'h1234_5678) ^ 4'h1), "I-field parity");
        chk(rxParityErr === 1'b1, "I-field parity flag");
      end
    join
    repeat (3) @(negedge clock);
    chk(rxParityErr === 1'b1, "parity flag held");
    wr(hdr_pkg::REG_CTRL, 32'h5);
    repeat (2) @(negedge clock);
    chk(rxParityErr === 1'b0 && wordTypeSel === hdr_pkg::SEL_STATUS, "accept clears flag");
    u_hdr_chan_src.put(32'h0, 1'b0, 1'b0, 1'b1);
    repeat (10) @(negedge clock);
    wr(hdr_pkg::REG_ERRCNT, 32'h0);
  endtask : t_ifield

  task automatic t_burst(input logic [31:0] base, input logic bad);
    logic [31:0] cw;
    cw = base ^ (base + 32'h1) ^ (base + 32'h2) ^ 32'h3 ^ {31'h0, bad};
    fork
      u_hdr_chan_src.burst(3, base, 1, bad);
      for (int i = 0; i < 3; i++)
      begin
        wait_word(hdr_pkg::SEL_BURST);
        chk(rxDataOut === base + 32'(i), "burst data");
        chk(rxParityOut === (u_hdr_chan_src.odd_par(base + 32'(i)) ^ {3'h0, i == 1}), "burst parity");
        chk(rxParityErr === (i == 1), "burst parity flag");
        chk(burstOut === 1'b1 && packetOut === 1'b1, "burst and packet lines");
      end
    join
    wait_word(hdr_pkg::SEL_CHECK);
    chk(rxDataOut === cw, "checkword presented");
    chk(rxCheckwordErr === bad, "checkword verdict");
    chk(burstOut === 1'b0, "burst line low at checkword");
  endtask : t_burst

  task automatic t_overrun;
    int n;
    @(posedge clock);
    clockEn <= 1'b0;
    // Odd count of dropped words, so the overrun toggle ends flipped
    u_hdr_chan_src.burst(7, 32'h100, 99, 1'b0);
    u_hdr_chan_src.finish();
    @(posedge clock);
    clockEn <= 1'b1;
    n = 0;
    while (resyncErr !== 1'b1 && n < 50)
    begin
      @(negedge clock);
      n++;
    end
    chk(resyncErr === 1'b1, "overrun flagged");
    if (resyncErr !== 1'b1)
    begin
      print_verdict();
    end
    @(posedge clock);
    opModeSel <= hdr_pkg::MODE_RESET;
    repeat (6) @(negedge clock);
    chk(resyncErr === 1'b0 && rxDataOut === 32'h0 && dataValid === 1'b0, "mode reset clears");
  endtask : t_overrun

  task automatic t_diag;
    logic [7:0] seen;
    seen = 8'h0;
    @(posedge clock);
    opModeSel <= hdr_pkg::MODE_DIAG;
    repeat (10) @(negedge clock);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clock);
      seen[wordTypeSel] = 1'b1;
      chk($countones({rxDataOut, rxParityOut, rxParityErr, rxCheckwordErr, resyncErr}) == 38, "walk");
    end
    chk(seen === 8'hff, "select codes visited");
  endtask : t_diag

  initial
  begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    // Link side leaves reset only on its own clock edges
    u_hdr_chan_src.finish();
    @(posedge clock);
    opModeSel <= hdr_pkg::MODE_FUNC;
    repeat (8) @(posedge clock);
    rd(hdr_pkg::REG_CTRL, 32'h4, "control reset value");
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, 32'h0, "unmapped read");
    t_ifield();
    t_burst(32'h0000_a5a0, 1'b0);
    t_burst(32'hffff_fffe, 1'b1);
    rd(hdr_pkg::REG_ERRCNT, 32'h0000_0102, "error counts");
    u_hdr_chan_src.finish();
    t_overrun();
    @(posedge clock);
    opModeSel <= hdr_pkg::MODE_FUNC;
    repeat (8) @(posedge clock);
    t_diag();
    print_verdict();
  end
endmodule : tb
